/* File: logic/frrc_defines.vh */
// frrc_defines.vh: constants for the fault restart retry controller
// assumes inclusion by bare name from the logic directory
`ifndef FRRC_DEFINES_VH
`define FRRC_DEFINES_VH
`define FRRC_RETRY_MSB 5
`define FRRC_RETRY_LSB 3
`define FRRC_DELAY_MSB 2
`define FRRC_DELAY_LSB 0
`define FRRC_RETRY_NONE 3'h0
`define FRRC_RETRY_ONE 3'h1
`define FRRC_RETRY_TWO 3'h2
`define FRRC_RETRY_THREE 3'h3
`define FRRC_CLK_MHZ 100
`define FRRC_UNIT_NS 1000
`define FRRC_UNIT_CYCLES ((`FRRC_UNIT_NS * `FRRC_CLK_MHZ) / 1000)
`endif

/* File: logic/frrc_retry_control.v */
// frrc_retry_control.v: retry policy after a fault shutdown of the output
// assumes fault and restart-success flags come from same-clock logic; ctrl pin is asynchronous
`timescale 1ns/1ns
`include "frrc_defines.vh"
module frrc_retry_control #(
  parameter UNIT_CYCLES = `FRRC_UNIT_CYCLES
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [7:0] i_response,
  input wire i_fault,
  input wire [15:0] i_unit_mult,
  input wire i_start_ok,
  input wire i_ctrl_pin,
  input wire i_op_on,
  output reg o_output_en,
  output reg o_restart_pulse,
  output reg o_latched_off,
  output reg [1:0] o_attempts
);
  localparam ST_RUN = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_TRY = 2'h2;
  localparam ST_LATCH = 2'h3;

  // two stages for the asynchronous control pin
  reg ctrl_meta;
  reg ctrl_sync;
  // registered control state
  reg on_prev;
  reg seen_off;
  reg [1:0] state;
  reg [31:0] wait_cnt;
  // next values, all worked out in one combinational process
  reg [1:0] next_state;
  reg [31:0] next_wait_cnt;
  reg next_seen_off;
  reg next_output_en;
  reg next_restart_pulse;
  reg next_latched_off;
  reg [1:0] next_attempts;
  // decoded settings
  reg [31:0] spacing;
  wire [2:0] retry_code;
  wire [2:0] delay_code;
  wire [1:0] retry_limit;
  // events seen this cycle
  wire on_cmd;
  wire on_rise;
  wire clear_fault;
  wire slot_done;
  wire attempt_ok;
  wire attempt_bad;
  wire limit_hit;

  // codes above three are outside this block and act as three
  function [1:0] limit_of(input [2:0] code);
    if (code == `FRRC_RETRY_NONE) begin
      limit_of = 2'h0;
    end else if (code == `FRRC_RETRY_ONE) begin
      limit_of = 2'h1;
    end else if (code == `FRRC_RETRY_TWO) begin
      limit_of = 2'h2;
    end else begin
      limit_of = 2'h3;
    end
  endfunction

  assign retry_code = i_response[`FRRC_RETRY_MSB:`FRRC_RETRY_LSB];
  assign delay_code = i_response[`FRRC_DELAY_MSB:`FRRC_DELAY_LSB];
  assign retry_limit = limit_of(retry_code);
  // output is commanded on only when both the pin and the operation command allow it
  assign on_cmd = ctrl_sync & i_op_on;
  // on_prev starts low, so a rise right after reset is possible; seen_off masks it
  assign on_rise = on_cmd & ~on_prev;
  // off seen, then on again, clears the latch
  assign clear_fault = seen_off & on_rise;
  // the slot of the running wait or attempt has run out
  assign slot_done = (wait_cnt == 32'h0);
  // a good start only counts while no fault is present
  assign attempt_ok = i_start_ok & ~i_fault;
  // an attempt fails on a new fault or when its slot ends without a good start
  assign attempt_bad = i_fault | slot_done;
  // attempts already made against the allowed number
  assign limit_hit = (o_attempts >= retry_limit);

  always @* begin
    // spacing counts start to start; a zero delay still waits one cycle
    // the product is 32 bits wide, so a far larger UNIT_CYCLES would overflow it
    spacing = {29'h0, delay_code} * {16'h0, i_unit_mult} * UNIT_CYCLES;
    if (spacing == 32'h0) begin
      spacing = 32'h1;
    end
  end

  // the pin may change at any time; only ctrl_sync is read by the logic
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_meta <= 1'b0;
      ctrl_sync <= 1'b0;
    end else begin
      ctrl_meta <= i_ctrl_pin;
      ctrl_sync <= ctrl_meta;
    end
  end

  always @* begin
    // defaults hold every register; only the restart pulse falls back to low
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_seen_off = seen_off;
    next_output_en = o_output_en;
    next_restart_pulse = 1'b0;
    next_latched_off = o_latched_off;
    next_attempts = o_attempts;
    case (state)
      ST_RUN: begin
        next_seen_off = 1'b0;
        next_output_en = on_cmd;
        if (i_fault) begin
          // shutdown: output off at once and attempts counted afresh
          next_output_en = 1'b0;
          next_attempts = 2'h0;
          if (retry_code == `FRRC_RETRY_NONE) begin
            next_state = ST_LATCH;
            next_latched_off = 1'b1;
          end else begin
            next_state = ST_WAIT;
            next_wait_cnt = spacing - 32'h1;
          end
        end
      end
      ST_WAIT: begin
        // faults are not looked at here, the output is already off
        if (slot_done) begin
          // one restart per expiry, counted against the retry code
          next_state = ST_TRY;
          next_attempts = o_attempts + 2'h1;
          next_restart_pulse = 1'b1;
          next_output_en = 1'b1;
          next_wait_cnt = spacing - 32'h1;
        end else begin
          next_wait_cnt = wait_cnt - 32'h1;
        end
      end
      ST_TRY: begin
        if (attempt_ok) begin
          // the restart held, so retrying ends here
          next_state = ST_RUN;
          next_attempts = 2'h0;
        end else if (attempt_bad && limit_hit) begin
          next_state = ST_LATCH;
          next_output_en = 1'b0;
          next_latched_off = 1'b1;
        end else if (attempt_bad && slot_done) begin
          // slot used up: the next attempt starts now, so the spacing stays exact
          next_attempts = o_attempts + 2'h1;
          next_restart_pulse = 1'b1;
          next_output_en = 1'b1;
          next_wait_cnt = spacing - 32'h1;
        end else if (attempt_bad) begin
          // early fault: off for the rest of the slot, the next start time is kept
          next_state = ST_WAIT;
          next_output_en = 1'b0;
          next_wait_cnt = wait_cnt - 32'h1;
        end else begin
          // attempt still running: count down its slot
          next_wait_cnt = wait_cnt - 32'h1;
        end
      end
      default: begin
        // latched: the output stays off until the host clears the fault
        next_output_en = 1'b0;
        if (!on_cmd) begin
          next_seen_off = 1'b1;
        end
        if (clear_fault) begin
          next_state = ST_RUN;
          next_latched_off = 1'b0;
          next_attempts = 2'h0;
        end
      end
    endcase
  end

  // control state
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_RUN;
      wait_cnt <= 32'h0;
      on_prev <= 1'b0;
      seen_off <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      on_prev <= on_cmd;
      seen_off <= next_seen_off;
    end
  end

  // registered outputs
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_output_en <= 1'b0;
      o_restart_pulse <= 1'b0;
      o_latched_off <= 1'b0;
      o_attempts <= 2'h0;
    end else begin
      o_output_en <= next_output_en;
      o_restart_pulse <= next_restart_pulse;
      o_latched_off <= next_latched_off;
      o_attempts <= next_attempts;
    end
  end
endmodule

/* File: tb/frrc_host.sv */
// host model: clears a latched fault with an off then on command
// assumes calls start just after a rising edge
`timescale 1ns/1ns
module frrc_host (
  input wire i_clk,
  output reg o_ctrl_pin = 1'h1,
  output reg o_op_on = 1'h1
);
  // four cycles off, so the two-flop pin synchroniser sees the off
  task power_cycle(input [1:0] sel);
    o_ctrl_pin <= !sel[0];
    o_op_on <= !sel[1];
    repeat (4) @(posedge i_clk);
    o_ctrl_pin <= 1'h1;
    o_op_on <= 1'h1;
  endtask
endmodule

/* File: tb/frrc_retry_properties.sv */
// assertions on the retry controller ports
// assumes response and unit stay put during a fault
`timescale 1ns/1ns
module frrc_props #(
  parameter UNIT_CYCLES = 1
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_fault,
  input wire i_ctrl_pin,
  input wire i_op_on,
  input wire [7:0] i_response,
  input wire [15:0] i_unit_mult,
  input wire o_output_en,
  input wire o_restart_pulse,
  input wire o_latched_off,
  input wire [1:0] o_attempts
);
  wire [2:0] code = i_response[5:3];
  wire [31:0] g_raw = i_response[2:0] * i_unit_mult * UNIT_CYCLES;
  // a zero delay still spaces attempts by one cycle
  wire [31:0] g = (g_raw == 32'h0) ? 32'h1 : g_raw;
  integer cnt;
  // counts from a fresh shutdown, so a re-wait after a failed attempt cannot reset it
  always @(posedge i_clk) cnt <= (o_restart_pulse || $fell(o_output_en) && !o_attempts) ? 1 : cnt + 1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_zero_latch: assert property (o_output_en && i_fault && !code |=> o_latched_off) else $error("latch");
  a_tries: assert property (o_latched_off && !code[2] |-> o_attempts == code[1:0])
    else $error("tries");
  a_spacing: assert property (o_restart_pulse |-> cnt == g)
    else $error("gap");
  a_latch_off: assert property (o_latched_off |-> !o_output_en) else $error("output on while latched");
  a_attempt_cap: assert property (o_restart_pulse && !code[2] |-> o_attempts != 2'h0 && o_attempts <= code[1:0])
    else $error("attempt beyond retry code");
  a_clear_on: assert property ($fell(o_latched_off) |-> i_op_on && i_ctrl_pin) else $error("clear");
  a_clear_zero: assert property ($fell(o_latched_off) |-> !o_attempts) else $error("kept");
  c_zero: cover property (o_latched_off && !code);
  c_three: cover property (o_attempts == 2'h3);
  c_clear: cover property ($fell(o_latched_off));
endmodule
bind frrc_retry_control frrc_props #(.UNIT_CYCLES(UNIT_CYCLES)) props (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_fault(i_fault),
  .i_ctrl_pin(i_ctrl_pin),
  .i_op_on(i_op_on),
  .i_response(i_response),
  .i_unit_mult(i_unit_mult),
  .o_output_en(o_output_en),
  .o_restart_pulse(o_restart_pulse),
  .o_latched_off(o_latched_off),
  .o_attempts(o_attempts)
);

/* File: tb/tb_top.sv */
// bench: retry codes zero to three, each cleared by pin, command or both
// assumes unit and UNIT_CYCLES of 1, so the spacing is the delay count
`timescale 1ns/1ns
module tb_top;
  reg i_clk = 1'h0, i_reset_n = 1'h0, i_fault = 1'h0, i_start_ok = 1'h0;
  reg [7:0] i_response = 8'h00;
  reg [15:0] i_unit_mult = 16'h0001;
  wire i_ctrl_pin, i_op_on, o_output_en, o_restart_pulse, o_latched_off;
  wire [1:0] o_attempts;
  integer n_errors = 0, check_count = 0, cyc = 0, np = 0, c, k, p0;
  frrc_retry_control #(.UNIT_CYCLES(1)) dut (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_response(i_response),
    .i_fault(i_fault),
    .i_unit_mult(i_unit_mult),
    .i_start_ok(i_start_ok),
    .i_ctrl_pin(i_ctrl_pin),
    .i_op_on(i_op_on),
    .o_output_en(o_output_en),
    .o_restart_pulse(o_restart_pulse),
    .o_latched_off(o_latched_off),
    .o_attempts(o_attempts)
  );
  frrc_host host (.i_clk(i_clk), .o_ctrl_pin(i_ctrl_pin), .o_op_on(i_op_on));
  initial forever #5 i_clk = ~i_clk;
  task check(input [7:0] seen, exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("errors %0d of %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    np <= np + o_restart_pulse;
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  task t_codes;
    for (c = 0; c < 4; c = c + 1) begin
      i_response <= {2'h0, c[2:0], 3'h3};
      @(posedge i_clk);
      p0 = np;
      i_fault <= 1'h1;
      @(posedge i_clk);
      i_fault <= 1'h0;
      for (k = 0; k < 60 && o_latched_off !== 1'h1; k = k + 1) @(posedge i_clk);
      repeat (2) @(posedge i_clk);
      check(np - p0, c);
      check({o_output_en, o_attempts}, c);
      host.power_cycle(c % 3 + 1);
      repeat (5) @(posedge i_clk);
      check({o_latched_off, o_attempts, o_output_en}, 1);
    end
  endtask
  // two retries allowed, but a good start on the first attempt ends the retrying
  task t_recover;
    i_response <= {2'h0, 3'h2, 3'h3};
    @(posedge i_clk);
    p0 = np;
    i_fault <= 1'h1;
    @(posedge i_clk);
    i_fault <= 1'h0;
    for (k = 0; k < 60 && o_restart_pulse !== 1'h1; k = k + 1) @(posedge i_clk);
    i_start_ok <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_start_ok <= 1'h0;
    repeat (8) @(posedge i_clk);
    check(np - p0, 1);
    check({o_latched_off, o_attempts, o_output_en}, 1);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'h1;
    repeat (5) @(posedge i_clk);
    t_codes;
    t_recover;
    results;
  end
endmodule
